/* File: pcr_params.svh */
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCR_IDX_REF_COUNT   10'h0E7
`define PCR_IDX_ACT_COUNT   10'h0E8
`define PCR_IDX_MEM_CAP     10'h0FE
`define PCR_IDX_CODE_SEL    10'h174
`define PCR_IDX_STACK_PTR   10'h175
`define PCR_IDX_ENTRY_PTR   10'h176
`define PCR_IDX_CHECK_CAP   10'h179

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define PCR_HI_WORD_BIT     12
`define PCR_IDX_LSB         2
`define PCR_IDX_MSB         11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCR_MEM_FIXED_BIT   8
`define PCR_MEM_WC_BIT      10
`define PCR_MEM_SMR_BIT     11
`define PCR_CHK_CTL_BIT     8
`define PCR_CHK_EXT_BIT     9
`define PCR_CHK_CMC_BIT     10
`define PCR_CHK_TES_BIT     11
`define PCR_CHK_EXT_LSB     16
`define PCR_CHK_SER_BIT     24
`define PCR_CHK_LOG_BIT     26
`define PCR_CODE_SEL_W      16

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define PCR_COUNT_RST       64'h0000_0000_0000_0000
`define PCR_FAST_RST        64'h0000_0000_0000_0000
`define PCR_RESP_OKAY       2'h0
`define PCR_RESP_SLVERR     2'h2

`endif

/* File: pcr_pkg.sv */
`default_nettype none

package pcr_pkg;

	typedef logic [63:0] pcr_word_t;
	typedef logic [1:0]  pcr_resp_t;

	// Fast system-call entry values as seen by the core
	typedef struct packed {
		logic [15:0] code_sel;
		logic [63:0] stack_ptr;
		logic [63:0] entry_ptr;
	} pcr_fast_call_s;

	// Counter pair as seen by the core
	typedef struct packed {
		logic [63:0] ref_count;
		logic [63:0] act_count;
	} pcr_counts_s;

	// Decoded register target
	typedef enum logic [2:0] {
		PCR_SEL_NONE,
		PCR_SEL_REF,
		PCR_SEL_ACT,
		PCR_SEL_MEM,
		PCR_SEL_CODE,
		PCR_SEL_STACK,
		PCR_SEL_ENTRY,
		PCR_SEL_CHECK
	} pcr_sel_e;

endpackage : pcr_pkg

`default_nettype wire

/* File: pcr_regs.sv */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_params.svh"

module pcr_regs #(
	parameter int ADDR_W             = 16,
	parameter bit COUNTERS_PRESENT   = 1'b1,
	parameter int VAR_RANGE_TOTAL    = 8,
	parameter bit FIXED_RANGE_SUP    = 1'b1,
	parameter bit WRITE_COMBINE_SUP  = 1'b1,
	parameter bit MGMT_RANGE_SUP     = 1'b1,
	parameter int BANK_TOTAL         = 8,
	parameter bit GLOBAL_CTL_PRESENT = 1'b1,
	parameter bit EXT_STATE_PRESENT  = 1'b0,
	parameter int EXT_STATE_TOTAL    = 0,
	parameter bit CORRECTED_SUP      = 1'b1,
	parameter bit THRESHOLD_SUP      = 1'b1,
	parameter bit SW_RECOVERY_SUP    = 1'b0,
	parameter bit FW_ERROR_LOG_SUP   = 1'b0
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  proc_active,
	input  wire logic                  ref_tick,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       counters_present,
	output pcr_pkg::pcr_fast_call_s    fast_call,
	output pcr_pkg::pcr_counts_s       counts
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < `PCR_HI_WORD_BIT + 1) begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end
	if (VAR_RANGE_TOTAL < 0 || VAR_RANGE_TOTAL > 255) begin : g_var_chk
		$error("VAR_RANGE_TOTAL must fit in eight bits");
	end
	if (BANK_TOTAL < 0 || BANK_TOTAL > 255) begin : g_bank_chk
		$error("BANK_TOTAL must fit in eight bits");
	end
	if (EXT_STATE_TOTAL < 0 || EXT_STATE_TOTAL > 255) begin : g_ext_chk
		$error("EXT_STATE_TOTAL must fit in eight bits");
	end
	if (!EXT_STATE_PRESENT && EXT_STATE_TOTAL != 0) begin : g_pair_chk
		$error("Extended state total without extended state");
	end

	// ----------------------------------------------------------------
	// Capability words, built from parameters
	// ----------------------------------------------------------------
	localparam logic [7:0] VAR_W  = 8'(VAR_RANGE_TOTAL);
	localparam logic [7:0] BANK_W = 8'(BANK_TOTAL);
	localparam logic [7:0] EXT_W  = 8'(EXT_STATE_TOTAL);

	pcr_pkg::pcr_word_t mem_cap;
	pcr_pkg::pcr_word_t check_cap;

	always_comb begin
		mem_cap = '0;
		mem_cap[7:0] = VAR_W;
		mem_cap[`PCR_MEM_FIXED_BIT] = FIXED_RANGE_SUP;
		mem_cap[`PCR_MEM_WC_BIT] = WRITE_COMBINE_SUP;
		mem_cap[`PCR_MEM_SMR_BIT] = MGMT_RANGE_SUP;
	end

	always_comb begin
		check_cap = '0;
		check_cap[7:0] = BANK_W;
		check_cap[`PCR_CHK_CTL_BIT] = GLOBAL_CTL_PRESENT;
		check_cap[`PCR_CHK_EXT_BIT] = EXT_STATE_PRESENT;
		check_cap[`PCR_CHK_EXT_LSB +: 8] = EXT_W;
		check_cap[`PCR_CHK_CMC_BIT] = CORRECTED_SUP;
		check_cap[`PCR_CHK_TES_BIT] = THRESHOLD_SUP;
		check_cap[`PCR_CHK_SER_BIT] = SW_RECOVERY_SUP;
		check_cap[`PCR_CHK_LOG_BIT] = FW_ERROR_LOG_SUP;
	end

	assign counters_present = COUNTERS_PRESENT;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic pcr_pkg::pcr_sel_e decode(
		input logic [ADDR_W-1:0] addr
	);
		logic [9:0] idx;
		logic       upper_clear;
		idx = addr[`PCR_IDX_MSB:`PCR_IDX_LSB];
		upper_clear = (addr >> (`PCR_HI_WORD_BIT + 1)) == '0;
		decode = pcr_pkg::PCR_SEL_NONE;
		if (upper_clear) begin
			unique case (idx)
				`PCR_IDX_REF_COUNT: begin
					if (COUNTERS_PRESENT)
						decode = pcr_pkg::PCR_SEL_REF;
				end
				`PCR_IDX_ACT_COUNT: begin
					if (COUNTERS_PRESENT)
						decode = pcr_pkg::PCR_SEL_ACT;
				end
				`PCR_IDX_MEM_CAP:   decode = pcr_pkg::PCR_SEL_MEM;
				`PCR_IDX_CODE_SEL:  decode = pcr_pkg::PCR_SEL_CODE;
				`PCR_IDX_STACK_PTR: decode = pcr_pkg::PCR_SEL_STACK;
				`PCR_IDX_ENTRY_PTR: decode = pcr_pkg::PCR_SEL_ENTRY;
				`PCR_IDX_CHECK_CAP: decode = pcr_pkg::PCR_SEL_CHECK;
				default:            decode = pcr_pkg::PCR_SEL_NONE;
			endcase
		end
	endfunction : decode

	// ----------------------------------------------------------------
	// Write channel capture
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] wr_addr;
	logic              aw_held;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              w_held;
	logic              wr_fire;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	// One write at a time: hold both halves until the response drains
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			wr_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			wr_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			w_held  <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held  <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	pcr_pkg::pcr_sel_e wr_sel;
	logic              wr_hi;

	assign wr_sel = decode(wr_addr);
	assign wr_hi  = wr_addr[`PCR_HI_WORD_BIT];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PCR_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			// Writes to capability words are accepted and dropped
			s_axi_bresp  <= (wr_sel == pcr_pkg::PCR_SEL_NONE) ?
				`PCR_RESP_SLVERR : `PCR_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Fast system-call entry registers
	// ----------------------------------------------------------------
	function automatic pcr_pkg::pcr_word_t merge(
		input pcr_pkg::pcr_word_t old,
		input logic               hi,
		input logic [31:0]        data,
		input logic [3:0]         strb
	);
		pcr_pkg::pcr_word_t res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				if (hi)
					res[32 + 8*b +: 8] = data[8*b +: 8];
				else
					res[8*b +: 8] = data[8*b +: 8];
			end
		end
		merge = res;
	endfunction : merge

	pcr_pkg::pcr_word_t code_word;
	pcr_pkg::pcr_word_t next_code_word;
	pcr_pkg::pcr_word_t stack_word;
	pcr_pkg::pcr_word_t entry_word;

	always_comb begin
		next_code_word = merge(code_word, wr_hi, wr_data, wr_strb);
		// Selector above bit 15 is reserved and kept at zero
		next_code_word[63:`PCR_CODE_SEL_W] = '0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			code_word <= `PCR_FAST_RST;
		else if (wr_fire && wr_sel == pcr_pkg::PCR_SEL_CODE)
			code_word <= next_code_word;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			stack_word <= `PCR_FAST_RST;
		else if (wr_fire && wr_sel == pcr_pkg::PCR_SEL_STACK)
			stack_word <= merge(stack_word, wr_hi, wr_data, wr_strb);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			entry_word <= `PCR_FAST_RST;
		else if (wr_fire && wr_sel == pcr_pkg::PCR_SEL_ENTRY)
			entry_word <= merge(entry_word, wr_hi, wr_data, wr_strb);
	end

	// Whole struct in one assignment keeps a single driver on the port
	assign fast_call = {code_word[`PCR_CODE_SEL_W-1:0], stack_word,
		entry_word};

	// ----------------------------------------------------------------
	// Activity counter pair
	// ----------------------------------------------------------------
	pcr_pkg::pcr_word_t ref_count;
	pcr_pkg::pcr_word_t act_count;
	logic               ref_inc;
	logic               act_inc;
	logic               ref_wrap;
	logic               act_wrap;
	logic               ref_clear;
	logic               act_clear;

	assign ref_inc  = COUNTERS_PRESENT && proc_active && ref_tick;
	assign act_inc  = COUNTERS_PRESENT && proc_active;
	assign ref_wrap = ref_inc && (&ref_count);
	assign act_wrap = act_inc && (&act_count);
	// Any write, whatever its strobes or half, empties the counter
	assign ref_clear = wr_fire && wr_sel == pcr_pkg::PCR_SEL_REF;
	assign act_clear = wr_fire && wr_sel == pcr_pkg::PCR_SEL_ACT;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			ref_count <= `PCR_COUNT_RST;
		else if (ref_clear || act_wrap)
			ref_count <= '0;
		else if (ref_inc)
			ref_count <= ref_count + 64'h1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			act_count <= `PCR_COUNT_RST;
		else if (act_clear || ref_wrap)
			act_count <= '0;
		else if (act_inc)
			act_count <= act_count + 64'h1;
	end

	assign counts = {ref_count, act_count};

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	pcr_pkg::pcr_sel_e  rd_sel;
	logic               rd_hi;
	pcr_pkg::pcr_word_t rd_word;
	logic [31:0]        snap_hi;
	logic [31:0]        rd_half;

	assign rd_sel = decode(s_axi_araddr);
	assign rd_hi  = s_axi_araddr[`PCR_HI_WORD_BIT];
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		unique case (rd_sel)
			pcr_pkg::PCR_SEL_REF:   rd_word = ref_count;
			pcr_pkg::PCR_SEL_ACT:   rd_word = act_count;
			pcr_pkg::PCR_SEL_MEM:   rd_word = mem_cap;
			pcr_pkg::PCR_SEL_CODE:  rd_word = code_word;
			pcr_pkg::PCR_SEL_STACK: rd_word = stack_word;
			pcr_pkg::PCR_SEL_ENTRY: rd_word = entry_word;
			pcr_pkg::PCR_SEL_CHECK: rd_word = check_cap;
			pcr_pkg::PCR_SEL_NONE:  rd_word = '0;
		endcase
	end

	// Counter high halves come from a snapshot taken by the low read,
	// so a low-then-high pair never tears across a carry.
	always_comb begin
		if (!rd_hi)
			rd_half = rd_word[31:0];
		else if (rd_sel == pcr_pkg::PCR_SEL_REF ||
				rd_sel == pcr_pkg::PCR_SEL_ACT)
			rd_half = snap_hi;
		else
			rd_half = rd_word[63:32];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			snap_hi <= '0;
		else if (s_axi_arvalid && s_axi_arready && !rd_hi &&
				(rd_sel == pcr_pkg::PCR_SEL_REF ||
				rd_sel == pcr_pkg::PCR_SEL_ACT))
			snap_hi <= rd_word[63:32];
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `PCR_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_half;
			s_axi_rresp  <= (rd_sel == pcr_pkg::PCR_SEL_NONE) ?
				`PCR_RESP_SLVERR : `PCR_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : pcr_regs

`default_nettype wire

/* File: pcr_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_params.svh"

// ----------------------------------------
// Counter pair and capability checks
// ----------------------------------------
module pcr_regs_monitor #(
	parameter int ADDR_W           = 16,
	parameter bit COUNTERS_PRESENT = 1'b1
) (
	input wire logic                 clock,
	input wire logic                 rst,
	input wire logic                 proc_active,
	input wire logic                 ref_tick,
	input wire logic [ADDR_W-1:0]    s_axi_araddr,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 s_axi_bvalid,
	input wire logic                 counters_present,
	input wire pcr_pkg::pcr_counts_s counts
);
	logic act_top;
	logic ref_top;
	logic rd_mem;
	logic rd_chk;

	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	assign act_top = &counts.act_count;
	assign ref_top = &counts.ref_count;
	assign rd_mem  = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ADDR_W'({`PCR_IDX_MEM_CAP, 2'h0});
	assign rd_chk  = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ADDR_W'({`PCR_IDX_CHECK_CAP, 2'h0});

	// A write that fires may clear a count in the same cycle
	idle_hold_a: assert property (
		!proc_active |=> $stable(counts) || $rose(s_axi_bvalid))
		else $error("counter moved while idle");
	act_step_a: assert property (
		proc_active && !act_top && !ref_top |=> $rose(s_axi_bvalid)
		|| counts.act_count == $past(counts.act_count) + 64'h1)
		else $error("actual count did not step");
	ref_step_a: assert property (
		proc_active && ref_tick && !act_top && !ref_top |=> $rose(s_axi_bvalid)
		|| counts.ref_count == $past(counts.ref_count) + 64'h1)
		else $error("reference count did not step");
	ref_hold_a: assert property (
		!ref_tick && !act_top |=> $stable(counts.ref_count)
		|| $rose(s_axi_bvalid))
		else $error("reference count moved without tick");
	// Wrap is far out of reach from reset; these guard the logic only
	act_wrap_a: assert property (
		proc_active && act_top |=> counts.ref_count == 64'h0)
		else $error("reference count kept on wrap");
	ref_wrap_a: assert property (
		proc_active && ref_tick && ref_top |=> counts.act_count == 64'h0)
		else $error("actual count kept on wrap");
	present_a: assert property (
		counters_present == COUNTERS_PRESENT)
		else $error("counter presence flag wrong");
	mem_resv_a: assert property (
		rd_mem |=> s_axi_rdata[31:12] == 20'h0 && !s_axi_rdata[9])
		else $error("memory range reserved bits set");
	chk_resv_a: assert property (
		rd_chk |=> s_axi_rdata[15:12] == 4'h0 && !s_axi_rdata[25]
		&& s_axi_rdata[31:27] == 5'h0)
		else $error("check capability reserved bits set");
endmodule : pcr_regs_monitor

bind pcr_regs pcr_regs_monitor #(
	.ADDR_W          (ADDR_W),
	.COUNTERS_PRESENT(COUNTERS_PRESENT)
) u_mon (
	.clock           (clock),
	.rst             (rst),
	.proc_active     (proc_active),
	.ref_tick        (ref_tick),
	.s_axi_araddr    (s_axi_araddr),
	.s_axi_arvalid   (s_axi_arvalid),
	.s_axi_arready   (s_axi_arready),
	.s_axi_rdata     (s_axi_rdata),
	.s_axi_bvalid    (s_axi_bvalid),
	.counters_present(counters_present),
	.counts          (counts)
);

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcr_params.svh"

module tb;
	logic                    clock = 1'b0;
	logic                    rst = 1'b1;
	logic                    proc_active = 1'b0;
	logic                    ref_tick = 1'b0;
	logic [15:0]             awaddr = 16'h0;
	logic                    awvalid = 1'b0;
	logic                    awready;
	logic [31:0]             wdata = 32'h0;
	logic [3:0]              wstrb = 4'h0;
	logic                    wvalid = 1'b0;
	logic                    wready;
	logic [1:0]              bresp;
	logic                    bvalid;
	logic                    bready = 1'b0;
	logic [15:0]             araddr = 16'h0;
	logic                    arvalid = 1'b0;
	logic                    arready;
	logic [31:0]             rdata;
	logic [1:0]              rresp;
	logic                    rvalid;
	logic                    rready = 1'b0;
	logic                    counters_present;
	pcr_pkg::pcr_fast_call_s fast_call;
	pcr_pkg::pcr_counts_s    counts;
	int                      err_count = 0;
	int                      comparisons = 0;
	logic [31:0]             lf = 32'h0001_3117;
	logic [63:0]             am = 64'h0;
	logic [63:0]             rm = 64'h0;
	logic [63:0]             fe [3];
	localparam logic [9:0]   FI [3] = '{`PCR_IDX_CODE_SEL,
		`PCR_IDX_STACK_PTR, `PCR_IDX_ENTRY_PTR};
	localparam logic [9:0]   CI [2] = '{`PCR_IDX_MEM_CAP, `PCR_IDX_CHECK_CAP};
	// 5 ranges, fixed, WC and mgmt; 8 banks, all flags, 3 extended
	localparam logic [63:0]  CE [2] = '{64'h0D05, 64'h0503_0F08};

	always #5 clock = ~clock;

	pcr_regs #(
		.VAR_RANGE_TOTAL  (5),
		.EXT_STATE_PRESENT(1'b1),
		.EXT_STATE_TOTAL  (3),
		.SW_RECOVERY_SUP  (1'b1),
		.FW_ERROR_LOG_SUP (1'b1)
	) dut (
		.clock(clock), .rst(rst), .proc_active(proc_active),
		.ref_tick(ref_tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .counters_present(counters_present),
		.fast_call(fast_call), .counts(counts)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx

	function automatic logic [15:0] ad(input logic [9:0] i, input logic h);
		return {3'h0, h, i, 2'h0};
	endfunction : ad

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [63:0] e,
			input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic hang(input string nm);
		err_count++;
		$display("MISMATCH %s expected handshake seen timeout", nm);
		report_and_stop();
	endtask : hang

	// Sampled at the falling edge, where handshake lines are settled
	task automatic wr(input logic [15:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		logic [1:0] r = 2'h3;
		bit         ta = 1'b0;
		bit         tw = 1'b0;
		bit         tb = 1'b0;
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge clock);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			tb = bvalid;
			r  = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!tb) hang("bvalid");
		else chk("bresp", 64'(er), 64'(r));
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d,
			output logic [1:0] r);
		bit ta = 1'b0;
		bit tr = 1'b0;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int n = 0; n < 50 && !tr; n++) begin
			@(negedge clock);
			ta = ta | (arvalid & arready);
			tr = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!tr) hang("rvalid");
	endtask : rd

	// Low half first: it latches the counter's high half
	task automatic rr(input logic [9:0] ix, input logic [63:0] e);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [1:0]  r1;
		logic [1:0]  r2;
		rd(ad(ix, 1'b0), lo, r1);
		rd(ad(ix, 1'b1), hi, r2);
		chk("rdata", e, {hi, lo});
		chk("rresp", 64'h0, 64'({r1, r2}));
	endtask : rr

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		chk("present", 64'h1, 64'(counters_present));
		rr(`PCR_IDX_REF_COUNT, 64'h0);
		rr(`PCR_IDX_ACT_COUNT, 64'h0);
		foreach (CI[k]) begin
			rr(CI[k], CE[k]);
			lf = nx(lf);
			wr(ad(CI[k], k[0]), lf, 4'hF, `PCR_RESP_OKAY);
			rr(CI[k], CE[k]);
		end
		wr(ad(10'h100, 1'b1), lf, 4'hF, `PCR_RESP_SLVERR);
		rd(ad(10'h100, 1'b0), d, r);
		chk("unmapped", 64'h2_0000_0000, {30'h0, r, d});
		$display("test capability done");
		foreach (FI[k]) begin
			lf = nx(lf);
			fe[k][31:0] = lf;
			lf = nx(lf);
			fe[k][63:32] = lf;
			wr(ad(FI[k], 1'b0), fe[k][31:0], 4'hF, `PCR_RESP_OKAY);
			wr(ad(FI[k], 1'b1), fe[k][63:32], 4'hF, `PCR_RESP_OKAY);
			if (k == 0) fe[k] = fe[k] & 64'hFFFF;
			rr(FI[k], fe[k]);
		end
		chk("fast_call", 64'h0, 64'(fast_call !== {fe[0][15:0], fe[1], fe[2]}));
		$display("test fast call done");
		for (int i = 0; i <= 300; i++) begin
			@(posedge clock);
			am += 64'(proc_active);
			rm += 64'(proc_active & ref_tick);
			lf = nx(lf);
			proc_active <= (i < 300) & (lf[0] | lf[1]);
			ref_tick    <= lf[2] & lf[5];
		end
		@(negedge clock);
		chk("ref_count", rm, counts.ref_count);
		chk("act_count", am, counts.act_count);
		rr(`PCR_IDX_REF_COUNT, rm);
		rr(`PCR_IDX_ACT_COUNT, am);
		wr(ad(`PCR_IDX_REF_COUNT, 1'b1), lf, 4'h0, `PCR_RESP_OKAY);
		rr(`PCR_IDX_REF_COUNT, 64'h0);
		rr(`PCR_IDX_ACT_COUNT, am);
		wr(ad(`PCR_IDX_ACT_COUNT, 1'b0), lf, 4'hF, `PCR_RESP_OKAY);
		rr(`PCR_IDX_ACT_COUNT, 64'h0);
		$display("test counters done");
		repeat (20) begin
			@(posedge clock);
			proc_active <= 1'b1;
		end
		// Idle before release, so no step check spans the reset
		@(posedge clock);
		rst         <= 1'b1;
		proc_active <= 1'b0;
		@(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk("rst_counts", 64'h0, 64'(counts !== '0));
		chk("rst_fast", 64'h0, 64'(fast_call !== '0));
		$display("test second reset done");
		report_and_stop();
	end
endmodule : tb

`default_nettype wire
